// >>> core/wwdt_pkg.sv
/*
  Constants, register map, field layouts and state carriers of the windowed
  watchdog timer. Assumes a 20 MHz APB clock and a 32-bit APB data path.
*/
// What this block does
// - Any reset leaves the watchdog on, slow 1 kHz source, longest timeout.
// - Timeout select 00 keeps the watchdog disabled on either source.
// - Writing 0x0055 then 0x00AA to the cause address restarts the period.
// - Writes to the cause address change the value it reads only by causing a watchdog reset.
// - Reaching the selected overflow count without service resets the system.
// - While enabled, any other value written to the cause address resets immediately.
// - Clock select 0 picks the 1 kHz source, 1 picks the bus clock.
// - Slow source codes 01, 10, 11 overflow after 2^5, 2^8, 2^10 cycles.
// - Bus source codes 01, 10, 11 overflow after 2^13, 2^16, 2^18 cycles.
// - Bus source with window enable accepts service only in last quarter.
// - The window opens after 6144, 49152 or 196608 bus cycles.
// - With the slow source the window enable has no effect.
// - First write to each option register clears the counter, latches it.
// - Later option register writes change nothing.
// - Bus source: counter holds in debug or stop, resumes afterwards.
// - Slow source: counter clears in debug or stop, restarts from zero.
// - A watchdog reset is recorded by its own cause bit.
`default_nettype none

package wwdt_pkg;

  localparam int unsigned CLK_HZ      = 20_000_000;
  localparam int unsigned LPO_HZ      = 1_000;
  localparam int unsigned LPO_DIV_CYC = CLK_HZ / LPO_HZ;

  localparam int unsigned ADDR_W = 12;
  localparam int unsigned CNT_W  = 18;
  localparam int unsigned IRQ_W  = 2;

  localparam logic [11:0] OFF_CAUSE = 12'h000;
  localparam logic [11:0] OFF_OPT1  = 12'h004;
  localparam logic [11:0] OFF_OPT2  = 12'h008;
  localparam logic [11:0] OFF_IRQST = 12'h00C;
  localparam logic [11:0] OFF_IRQMS = 12'h010;
  localparam logic [11:0] OFF_COUNT = 12'h014;

  localparam logic [15:0] SVC_KEY1 = 16'h0055;
  localparam logic [15:0] SVC_KEY2 = 16'h00AA;

  localparam int unsigned CAUSE_POR_BIT = 0;
  localparam int unsigned CAUSE_WDT_BIT = 1;
  localparam logic [1:0]  CAUSE_POR     = 2'h1;
  localparam logic [1:0]  CAUSE_WDT     = 2'h2;

  localparam int unsigned OPT1_TSEL_LSB = 0;
  localparam int unsigned OPT2_CSEL_BIT = 0;
  localparam int unsigned OPT2_WEN_BIT  = 1;
  localparam logic [1:0]  TSEL_RST      = 2'h3;
  localparam logic        CSEL_RST      = 1'h0;
  localparam logic        WEN_RST       = 1'h0;

  localparam int unsigned IRQ_SVC_BIT = 0;
  localparam int unsigned IRQ_WIN_BIT = 1;

  localparam logic [2:0] RST_HOLD_CYC = 3'h4;

  localparam logic [17:0] LIM_LPO_1 = 18'h0001F;
  localparam logic [17:0] LIM_LPO_2 = 18'h000FF;
  localparam logic [17:0] LIM_LPO_3 = 18'h003FF;
  localparam logic [17:0] LIM_BUS_1 = 18'h01FFF;
  localparam logic [17:0] LIM_BUS_2 = 18'h0FFFF;
  localparam logic [17:0] LIM_BUS_3 = 18'h3FFFF;
  localparam logic [17:0] WIN_BUS_1 = 18'h01800;
  localparam logic [17:0] WIN_BUS_2 = 18'h0C000;
  localparam logic [17:0] WIN_BUS_3 = 18'h30000;

  typedef struct packed {
    logic [1:0]       tsel;
    logic             csel;
    logic             wen;
    logic             opt1_lock;
    logic             opt2_lock;
    logic [CNT_W-1:0] cnt;
    logic             armed;
    logic [1:0]       cause;
    logic [2:0]       hold;
    logic [IRQ_W-1:0] irq_st;
    logic [IRQ_W-1:0] irq_mask;
    logic [31:0]      prdata;
    logic             pslverr;
  } wwdt_state_t;

  typedef struct packed {
    logic [15:0] cnt;
    logic        tick;
  } wwdt_div_t;

  // Last count value before overflow for a source and timeout code.
  function automatic logic [17:0] ovf_limit(input logic [1:0] tsel,
                                            input logic       csel);
    logic [17:0] lim;
    lim = LIM_LPO_3;
    case ({csel, tsel})
      3'h1:    lim = LIM_LPO_1;
      3'h2:    lim = LIM_LPO_2;
      3'h3:    lim = LIM_LPO_3;
      3'h5:    lim = LIM_BUS_1;
      3'h6:    lim = LIM_BUS_2;
      3'h7:    lim = LIM_BUS_3;
      default: lim = LIM_LPO_3;
    endcase
    return lim;
  endfunction : ovf_limit

  // Count at which service becomes legal in windowed mode.
  function automatic logic [17:0] win_open(input logic [1:0] tsel);
    logic [17:0] w;
    w = WIN_BUS_3;
    case (tsel)
      2'h1:    w = WIN_BUS_1;
      2'h2:    w = WIN_BUS_2;
      default: w = WIN_BUS_3;
    endcase
    return w;
  endfunction : win_open

endpackage : wwdt_pkg

`default_nettype wire

// >>> core/wwdt_lpo_div.sv
/*
  Divider that turns the bus clock into the 1 kHz slow-source enable pulse.
  Assumes pclk is the only clock; the pulse lasts one pclk cycle.
*/
`default_nettype none

module wwdt_lpo_div #(
  parameter int unsigned DIV = wwdt_pkg::LPO_DIV_CYC
) (
  input  wire logic pclk,
  input  wire logic presetn,
  output logic      tick
);
  import wwdt_pkg::*;

  wwdt_div_t s_q;
  wwdt_div_t s_d;

  always_comb begin
    s_d = s_q;
    s_d.tick = 1'b0;
    if (s_q.cnt >= 16'(DIV - 1)) begin
      s_d.cnt  = 16'h0000;
      s_d.tick = 1'b1;
    end else begin
      s_d.cnt = s_q.cnt + 16'h0001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign tick = s_q.tick;

endmodule : wwdt_lpo_div

`default_nettype wire

// >>> core/wwdt_top.sv
/*
  Windowed watchdog timer with an APB register slave, a serviced-event and window-open
  interrupt and a system reset request. Assumes all inputs are synchronous
  to pclk and that presetn is the power-on reset of the block.
*/
// Our own choices: register access over APB and the placing of the registers.
`default_nettype none

module wwdt_top #(
  parameter int unsigned LPO_DIV = wwdt_pkg::LPO_DIV_CYC
) (
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [wwdt_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]                pwdata,
  output logic      [31:0]                prdata,
  output logic                            pready,
  output logic                            pslverr,
  input  wire logic                       dbg_mode,
  input  wire logic                       stop_mode,
  output logic                            sys_reset_req,
  output logic                            irq
);
  import wwdt_pkg::*;

  wwdt_state_t s_q;
  wwdt_state_t s_d;

  logic        lpo_tick;
  logic        tick_en;
  logic        frozen;
  logic        enabled;
  logic        active;
  logic        wr_acc;
  logic        wr_cause;
  logic        is_key1;
  logic        is_key2;
  logic        in_window;
  logic        svc_done;
  logic        fire;
  logic        ev_win;
  logic [17:0] lim;

  wwdt_lpo_div #(
    .DIV     (LPO_DIV)
  ) u_lpo_div (
    .pclk    (pclk),
    .presetn (presetn),
    .tick    (lpo_tick)
  );

  // A watchdog reset restores the option, counter and arming defaults but keeps the
  // cause and interrupt registers; the bus still answers during the request but writes are dropped meanwhile.
  assign active    = (s_q.hold == 3'h0);
  assign enabled   = (s_q.tsel != 2'h0);
  assign tick_en   = s_q.csel ? 1'b1 : lpo_tick;
  assign frozen    = dbg_mode | stop_mode;
  assign lim       = ovf_limit(s_q.tsel, s_q.csel);
  assign wr_acc    = psel & penable & pwrite & active;
  assign wr_cause  = wr_acc & (paddr == OFF_CAUSE);
  assign is_key1   = (pwdata[15:0] == SVC_KEY1);
  assign is_key2   = (pwdata[15:0] == SVC_KEY2);
  // The slow source never applies the window, whatever window_enable says.
  assign in_window = !(s_q.csel & s_q.wen) ||
                     (s_q.cnt >= win_open(s_q.tsel));
  assign svc_done  = wr_cause & enabled & is_key2 & s_q.armed & in_window;

  always_comb begin
    s_d    = s_q;
    fire   = 1'b0;
    ev_win = 1'b0;
    if (!active) begin
      s_d.hold = s_q.hold - 3'h1;
      if (s_q.hold == 3'h1) begin
        s_d.tsel      = TSEL_RST;
        s_d.csel      = CSEL_RST;
        s_d.wen       = WEN_RST;
        s_d.opt1_lock = 1'b0;
        s_d.opt2_lock = 1'b0;
        s_d.cnt       = '0;
        s_d.armed     = 1'b0;
      end
    end else begin
      if (!enabled) begin
        s_d.cnt = '0;
      end else if (frozen && !s_q.csel) begin
        s_d.cnt = '0;
      end else if (frozen && s_q.csel) begin
        s_d.cnt = s_q.cnt;
      end else if (tick_en) begin
        if (s_q.cnt == lim) begin
          // A service that lands on the expiry edge is still in time.
          fire = !svc_done;
        end else begin
          s_d.cnt = s_q.cnt + 18'h00001;
        end
        if (s_q.csel && s_q.wen &&
            (s_q.cnt + 18'h00001 == win_open(s_q.tsel))) begin
          ev_win = 1'b1;
        end
      end
      if (wr_acc) begin
        case (paddr)
          OFF_CAUSE: begin
            // The stored cause is never written here.
            if (enabled) begin
              if (!(is_key1 || is_key2)) begin
                fire = 1'b1;
              end else if (!in_window) begin
                fire = 1'b1;
              end else if (is_key1) begin
                s_d.armed = 1'b1;
              end else if (s_q.armed) begin
                s_d.cnt   = '0;
                s_d.armed = 1'b0;
              end else begin
                s_d.armed = 1'b0;
              end
            end
          end
          OFF_OPT1: begin
            if (!s_q.opt1_lock) begin
              s_d.tsel      = pwdata[OPT1_TSEL_LSB +: 2];
              s_d.opt1_lock = 1'b1;
              s_d.cnt       = '0;
              s_d.armed     = 1'b0;
            end
          end
          OFF_OPT2: begin
            if (!s_q.opt2_lock) begin
              s_d.csel      = pwdata[OPT2_CSEL_BIT];
              s_d.wen       = pwdata[OPT2_WEN_BIT];
              s_d.opt2_lock = 1'b1;
              s_d.cnt       = '0;
              s_d.armed     = 1'b0;
            end
          end
          OFF_IRQST: begin
            s_d.irq_st = s_q.irq_st & ~pwdata[IRQ_W-1:0];
          end
          OFF_IRQMS: begin
            s_d.irq_mask = pwdata[IRQ_W-1:0];
          end
          default: begin
            s_d.irq_mask = s_q.irq_mask;
          end
        endcase
      end
      // Events are merged after the clear so a same-cycle event survives.
      s_d.irq_st[IRQ_SVC_BIT] = s_d.irq_st[IRQ_SVC_BIT] | svc_done;
      s_d.irq_st[IRQ_WIN_BIT] = s_d.irq_st[IRQ_WIN_BIT] | ev_win;
      if (fire) begin
        s_d.hold  = RST_HOLD_CYC;
        s_d.cause = CAUSE_WDT;
        s_d.cnt   = '0;
        s_d.armed = 1'b0;
      end
    end
    // Read data is captured in the setup phase so that pready can be high
    // in the first access cycle without a combinational read path.
    if (psel && !penable) begin
      s_d.pslverr = 1'b0;
      case (paddr)
        OFF_CAUSE: s_d.prdata = {30'h0, s_q.cause};
        OFF_OPT1:  s_d.prdata = {30'h0, s_q.tsel};
        OFF_OPT2:  s_d.prdata = {30'h0, s_q.wen, s_q.csel};
        OFF_IRQST: s_d.prdata = {30'h0, s_q.irq_st};
        OFF_IRQMS: s_d.prdata = {30'h0, s_q.irq_mask};
        OFF_COUNT: s_d.prdata = {14'h0, s_q.cnt};
        default: begin
          s_d.prdata  = 32'h0000_0000;
          s_d.pslverr = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q           <= '0;
      s_q.tsel      <= TSEL_RST;
      s_q.csel      <= CSEL_RST;
      s_q.wen       <= WEN_RST;
      s_q.cause     <= CAUSE_POR;
    end else begin
      s_q <= s_d;
    end
  end

  assign prdata        = s_q.prdata;
  assign pslverr       = s_q.pslverr;
  assign pready        = 1'b1;
  assign sys_reset_req = (s_q.hold != 3'h0);
  assign irq           = |(s_q.irq_st & s_q.irq_mask);

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  chk_soft_defaults: assert property (
    (s_q.hold == 3'h1) |=> (s_q.tsel == TSEL_RST && !s_q.csel &&
                            !s_q.opt1_lock && !sys_reset_req))
    else $error("defaults not restored after watchdog reset");

  chk_disabled_idle: assert property (
    (active && !enabled) |=> (s_q.cnt == 18'h00000 && !sys_reset_req))
    else $error("disabled watchdog counted or fired");

  chk_service_restart: assert property (
    svc_done |=> (s_q.cnt == 18'h00000 && !sys_reset_req))
    else $error("valid service did not restart the period");

  chk_cause_stable: assert property (
    (!fire && active) |=> $stable(s_q.cause))
    else $error("cause changed without a watchdog reset");

  chk_timeout_fire: assert property (
    (active && enabled && tick_en && !frozen && s_q.cnt == lim &&
     !wr_acc) |=> sys_reset_req [*4] ##1 !sys_reset_req)
    else $error("overflow did not give a four-cycle reset request");

  chk_bad_key: assert property (
    (wr_cause && enabled && !is_key1 && !is_key2)
      |=> (sys_reset_req && s_q.cause[CAUSE_WDT_BIT]))
    else $error("bad service value did not reset at once");

  chk_early_service: assert property (
    (wr_cause && enabled && s_q.csel && s_q.wen &&
     s_q.cnt < win_open(s_q.tsel)) |=> sys_reset_req)
    else $error("premature windowed service accepted");

  chk_slow_nowindow: assert property (
    (wr_cause && enabled && !s_q.csel && is_key1 && !frozen &&
     !(tick_en && s_q.cnt == lim)) |=> (!sys_reset_req && s_q.armed))
    else $error("window applied on the slow source");

  chk_option_lock: assert property (
    (wr_acc && paddr == OFF_OPT1 && !s_q.opt1_lock)
      |=> (s_q.opt1_lock && s_q.cnt == 18'h00000))
    else $error("first option write did not lock and clear");

  chk_locked_stable: assert property (
    (s_q.opt1_lock && s_q.opt2_lock && s_q.hold != 3'h1)
      |=> ($stable(s_q.tsel) && $stable(s_q.csel) && $stable(s_q.wen)))
    else $error("locked option settings changed");

  chk_bus_freeze: assert property (
    (active && enabled && s_q.csel && frozen && !psel) |=> $stable(s_q.cnt))
    else $error("bus-clock counter moved in debug or stop");

  chk_slow_clear: assert property (
    (active && enabled && !s_q.csel && frozen && !psel)
      |=> (s_q.cnt == 18'h00000))
    else $error("slow-source counter not cleared in debug or stop");

  // The request must last its full span whatever started it.
  chk_req_width: assert property (
    $rose(sys_reset_req) |-> sys_reset_req [*4] ##1 !sys_reset_req)
    else $error("reset request not held for four cycles");

  chk_hold_count: assert property (
    !active |=> (s_q.hold == $past(s_q.hold) - 3'h1))
    else $error("reset hold counter skipped a step");

  chk_fire_cause: assert property (
    fire |=> (s_q.cause == CAUSE_WDT && s_q.hold == RST_HOLD_CYC))
    else $error("watchdog reset not recorded as its cause");

  chk_soft_unlock: assert property (
    (s_q.hold == 3'h1) |=> (!s_q.opt2_lock && !s_q.wen &&
                            s_q.cnt == 18'h00000 && !s_q.armed))
    else $error("soft reset left settings or arming behind");

  // Bounds the counter so a stale limit can never let it run past.
  chk_count_limit: assert property (
    s_q.cnt <= lim)
    else $error("counter passed the overflow count");

  chk_bus_step: assert property (
    (active && enabled && s_q.csel && !frozen && !wr_acc && s_q.cnt != lim)
      |=> (s_q.cnt == $past(s_q.cnt) + 18'h00001))
    else $error("bus-clock counter missed a cycle");

  chk_slow_step: assert property (
    (active && enabled && !s_q.csel && !frozen && !lpo_tick && !wr_acc)
      |=> $stable(s_q.cnt))
    else $error("slow-source counter moved without a tick");

  chk_window_late: assert property (
    (wr_cause && enabled && s_q.csel && s_q.wen && is_key1 &&
     s_q.cnt >= win_open(s_q.tsel) && s_q.cnt != lim)
      |=> (!sys_reset_req && s_q.armed))
    else $error("service inside the open window refused");

  // A lone second value only disarms; it is not a bad value.
  chk_key2_unarmed: assert property (
    (wr_cause && enabled && is_key2 && !s_q.armed && in_window &&
     !(tick_en && !frozen && s_q.cnt == lim)) |=> !sys_reset_req)
    else $error("second service value alone caused a reset");

  chk_opt2_lock: assert property (
    (wr_acc && paddr == OFF_OPT2 && !s_q.opt2_lock)
      |=> (s_q.opt2_lock && s_q.cnt == 18'h00000 && !s_q.armed))
    else $error("option two write did not lock and clear");

  chk_lock_stays: assert property (
    (s_q.opt1_lock && active) |=> s_q.opt1_lock)
    else $error("option lock dropped without a reset");

  chk_frozen_nofire: assert property (
    (active && frozen && !psel) |=> !sys_reset_req)
    else $error("watchdog fired while debug or stop froze it");

  chk_cause_read: assert property (
    (psel && !penable && paddr == OFF_CAUSE)
      |=> (prdata == {30'h0, $past(s_q.cause)}))
    else $error("cause address read returned wrong data");

  chk_svc_flag: assert property (
    svc_done |=> s_q.irq_st[IRQ_SVC_BIT])
    else $error("service event flag not set");

  chk_irq_clear: assert property (
    (wr_acc && paddr == OFF_IRQST && pwdata[IRQ_W-1:0] == 2'h3 &&
     !ev_win) |=> (s_q.irq_st == 2'h0))
    else $error("status bits not cleared by writing ones");

  // Unmapped reads must not alias onto a real register.
  chk_unmapped_err: assert property (
    (psel && !penable && paddr > OFF_COUNT) |=> (pslverr && prdata == 32'h0))
    else $error("unmapped read not flagged");

  cov_service:   cover property (svc_done);
  cov_timeout:   cover property (active && tick_en && s_q.cnt == lim &&
                                 enabled && !frozen);
  cov_window:    cover property (ev_win);
  cov_irq:       cover property ($rose(irq));
  cov_early_fire: cover property (wr_cause && enabled && s_q.csel &&
                                  s_q.wen && !in_window);

endmodule : wwdt_top

`default_nettype wire

// >>> verif/test_windowed_watchdog_timer.sv
/*
  Self-checking bench for the windowed watchdog timer: APB tasks and
  directed scenarios. Assumes the core files are compiled first.
*/
`default_nettype none

module test_windowed_watchdog_timer;
  timeunit 1ns;
  timeprecision 1ps;
  import wwdt_pkg::*;

  logic              pclk;
  logic              presetn;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic [ADDR_W-1:0] paddr;
  logic [31:0]       pwdata;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  logic              dbg_mode;
  logic              stop_mode;
  logic              sys_reset_req;
  logic              irq;
  logic [31:0]       rdata;
  logic              rerr;
  logic              fired;
  logic [31:0]       held;
  int                n_cyc;
  int                failures;
  int                n_tests;

  // A short slow-source divider keeps the long overflow counts affordable.
  wwdt_top #(.LPO_DIV(4)) DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .dbg_mode(dbg_mode),
    .stop_mode(stop_mode), .sys_reset_req(sys_reset_req), .irq(irq)
  );

  always #25 pclk = ~pclk;

  task automatic report_and_stop;
    $display("failures=%0d n_tests=%0d", failures, n_tests);
    if (failures == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) failures++;
    rdata = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [11:0] a);
    xfer(1'b0, a, 32'h0000_0000);
  endtask : rd

  task automatic service;
    wr(OFF_CAUSE, {16'h0000, SVC_KEY1});
    wr(OFF_CAUSE, {16'h0000, SVC_KEY2});
  endtask : service

  // Samples on the falling edge so registered outputs have settled.
  task automatic wait_req(input int lim);
    n_cyc = 0;
    do begin
      @(negedge pclk);
      n_cyc++;
    end while (sys_reset_req !== 1'b1 && n_cyc < lim);
    fired = (sys_reset_req === 1'b1);
  endtask : wait_req

  task automatic hold_chk;
    held = 0;
    while (sys_reset_req === 1'b1 && held < 10) begin
      @(negedge pclk);
      held++;
    end
    chk(held, {29'h0, RST_HOLD_CYC});
  endtask : hold_chk

  task automatic near(input int lo, input int hi);
    chk({31'h0, (n_cyc >= lo && n_cyc <= hi)}, 32'h1);
  endtask : near

  task automatic do_reset;
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
  endtask : do_reset

  initial begin
    repeat (60000) @(posedge pclk);
    failures++;
    report_and_stop;
  end

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    dbg_mode = 1'b0;
    stop_mode = 1'b0;
    failures = 0;
    n_tests = 0;
    do_reset;
    rd(OFF_CAUSE);
    chk(rdata, {30'h0, CAUSE_POR});
    rd(OFF_OPT1);
    chk(rdata & 32'h3, {30'h0, TSEL_RST});
    rd(OFF_OPT2);
    chk(rdata & 32'h3, 32'h0);
    rd(12'h020);
    chk({31'h0, rerr}, 32'h1);
    chk(rdata, 32'h0);
    wr(OFF_IRQMS, 32'h1);
    wr(OFF_CAUSE, {16'h0000, SVC_KEY1});
    rd(OFF_CAUSE);
    chk(rdata, {30'h0, CAUSE_POR});
    wr(OFF_CAUSE, {16'h0000, SVC_KEY2});
    @(negedge pclk);
    chk({30'h0, sys_reset_req, irq}, 32'h1);
    wr(OFF_IRQST, 32'h3);
    @(negedge pclk);
    chk({31'h0, irq}, 32'h0);
    // Slow source, shortest code; the late option write must be ignored.
    wr(OFF_OPT1, 32'h1);
    wr(OFF_OPT2, 32'h0);
    wr(OFF_OPT1, 32'h0);
    repeat (100) @(posedge pclk);
    service;
    wait_req(300);
    chk({31'h0, fired}, 32'h1);
    near(118, 140);
    hold_chk;
    rd(OFF_CAUSE);
    chk(rdata, {30'h0, CAUSE_WDT});
    rd(OFF_OPT1);
    chk(rdata & 32'h3, {30'h0, TSEL_RST});
    wr(OFF_CAUSE, 32'h0000_0012);
    wait_req(3);
    chk({31'h0, fired}, 32'h1);
    hold_chk;
    wr(OFF_OPT1, 32'h0);
    wr(OFF_OPT2, 32'h0);
    wr(OFF_CAUSE, 32'h0000_0012);
    wait_req(4400);
    chk({31'h0, fired}, 32'h0);
    do_reset;
    // Window enable with the slow source: an early service is harmless.
    wr(OFF_OPT1, 32'h1);
    wr(OFF_OPT2, 32'h2);
    wr(OFF_CAUSE, {16'h0000, SVC_KEY1});
    wait_req(4);
    chk({31'h0, fired}, 32'h0);
    wr(OFF_CAUSE, {16'h0000, SVC_KEY2});
    repeat (20) @(posedge pclk);
    stop_mode <= 1'b1;
    repeat (40) @(posedge pclk);
    rd(OFF_COUNT);
    chk(rdata, 32'h0);
    stop_mode <= 1'b0;
    wait_req(300);
    near(118, 140);
    hold_chk;
    wr(OFF_OPT1, 32'h1);
    wr(OFF_OPT2, 32'h3);
    wr(OFF_CAUSE, {16'h0000, SVC_KEY1});
    wait_req(3);
    chk({31'h0, fired}, 32'h1);
    hold_chk;
    wr(OFF_OPT1, 32'h1);
    wr(OFF_OPT2, 32'h3);
    repeat (6150) @(posedge pclk);
    service;
    repeat (20) @(posedge pclk);
    dbg_mode <= 1'b1;
    wait_req(4);
    chk({31'h0, fired}, 32'h0);
    rd(OFF_IRQST);
    chk(rdata, 32'h3);
    rd(OFF_COUNT);
    chk(rdata, 32'h0000_0014);
    held = rdata;
    repeat (30) @(posedge pclk);
    rd(OFF_COUNT);
    chk(rdata, held);
    dbg_mode <= 1'b0;
    wait_req(8300);
    chk({31'h0, fired}, 32'h1);
    near(8168, 8178);
    hold_chk;
    report_and_stop;
  end
endmodule : test_windowed_watchdog_timer

`default_nettype wire
